/* rtl/fbc_defines.svh */
// Register map and timing constants of the controller
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

// Register byte offsets on the AXI4-Lite port
`define FBC_OFS_CTRL 4'h0
`define FBC_OFS_ADDR 4'h4
`define FBC_OFS_DATA 4'h8
`define FBC_OFS_STAT 4'hc

// Control register fields
`define FBC_CTRL_GO 0
`define FBC_CTRL_OP_LSB 1
`define FBC_CTRL_OP_MSB 3
`define FBC_CTRL_BYTE 4
`define FBC_CTRL_ACCEL 5
`define FBC_CTRL_RESET 6
`define FBC_CTRL_RESET_VAL 32'h0000_0000

// Status register fields
`define FBC_STAT_BUSY 0
`define FBC_STAT_RDY 1
`define FBC_STAT_DONE 2
`define FBC_STAT_BYPASS 3

// Times in ns and cycles at 250 MHz (4 ns period)
`define FBC_CLK_NS 4
`define FBC_ACC_NS 70
`define FBC_CE_NS 70
`define FBC_WP_NS 35
`define FBC_RP_NS 500
`define FBC_RH_NS 50
`define FBC_CYC(ns) (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`endif

/* rtl/fbc_pkg.sv */
// Types shared by the flash bus controller files
package fbc_pkg;

    // Operations that software can start
    typedef enum logic [2:0] {
        FBC_OP_READ,
        FBC_OP_WRITE,
        FBC_OP_PROGRAM,
        FBC_OP_BYPASS_ENTER,
        FBC_OP_BYPASS_PROGRAM,
        FBC_OP_BYPASS_EXIT,
        FBC_OP_AUTOSELECT,
        FBC_OP_RESET_CMD
    } fbc_op_type;

    // One bus cycle towards the flash pins
    typedef struct packed {
        logic write;
        logic [22:0] addr;
        logic [15:0] data;
    } fbc_cycle_type;

    // Flash control pins, all active low
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic output_gate_n;
        logic reset_n;
        logic byte_mode_n;
    } fbc_ctl_type;

endpackage

/* rtl/fbc_cycle.sv */
// One timed read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defines.svh"

module fbc_cycle #(
    parameter int ACC_CYC = `FBC_CYC(`FBC_ACC_NS),
    parameter int WP_CYC = `FBC_CYC(`FBC_WP_NS)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire fbc_pkg::fbc_cycle_type cyc,
    input wire logic [15:0] dq_sync,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    output logic cs_n,
    output logic we_n,
    output logic oe_n,
    output logic [22:0] addr,
    output logic [15:0] dq_o,
    output logic dq_oe_n
);
    localparam int LEN = (ACC_CYC > WP_CYC) ? ACC_CYC + 3 : WP_CYC + 3;
    logic [7:0] cnt;
    logic wr;
    wire last = (cnt == 8'h01);

    ////////////////////////////////////////////////////////////////////////
    // Counter; the 3 extra cycles cover setup, hold and bus turnaround
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 8'h00;
            wr <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start && cnt == 8'h00) begin
                cnt <= LEN[7:0];
                wr <= cyc.write;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                done <= last;
                if (last && !wr)
                    rdata <= dq_sync;
            end
        end
    end

    // Address and data latched at start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr <= 23'h000000;
            dq_o <= 16'h0000;
        end else if (start && cnt == 8'h00) begin
            addr <= cyc.addr;
            dq_o <= cyc.data;
        end
    end

    // Chip select whole cycle, write strobe mid, gate for reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            dq_oe_n <= 1'b1;
        end else begin
            cs_n <= !(cnt > 8'h01 || (start && cnt == 8'h00));
            we_n <= !(wr && cnt > 8'h02 && cnt < LEN[7:0]);
            oe_n <= !(!wr && cnt > 8'h01 && cnt < LEN[7:0]);
            dq_oe_n <= !(wr && cnt > 8'h01);
        end
    end

    assign busy = (cnt != 8'h00);

    // Writes never open the output gate
    property p_we_no_oe;
        @(posedge aclk) disable iff (!aresetn) !we_n |-> oe_n;
    endproperty
    a_we_no_oe: assert property (p_we_no_oe)
        else $error("write strobe with output gate");
endmodule
`default_nettype wire

/* rtl/fbc_top.sv */
// AXI4-Lite controller driving a dual-bank parallel NOR flash
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defines.svh"

module fbc_top #(
    parameter int RP_CYC = `FBC_CYC(`FBC_RP_NS),
    parameter int RH_CYC = `FBC_CYC(`FBC_RH_NS),
    parameter int CE_CYC = `FBC_CYC(`FBC_CE_NS)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_i,
    output logic [15:0] flash_dq_o,
    output logic [15:0] flash_dq_oe_n,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_gate_n,
    output logic reset_n,
    output logic byte_mode_n,
    output logic protect_accelerate_pin,
    input wire logic ready_busy_n
);
    typedef enum logic [3:0] {
        ST_RESET, ST_RECOVER, ST_IDLE, ST_ISSUE, ST_WAIT, ST_STANDBY_EXIT
    } fbc_state_type;

    fbc_state_type state;
    fbc_state_type next_state;
    logic [31:0] ctrl;
    logic [22:0] reg_addr;
    logic [15:0] reg_data;
    logic [15:0] rd_data;
    logic done_flag, bypass;
    logic [2:0] seq_idx, seq_len;
    logic [15:0] tmr;
    logic [15:0] dq_s1, dq_sync;
    logic rb_s1, rb_sync, aw_hold, w_hold;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic start;
    fbc_pkg::fbc_cycle_type cyc;
    logic cyc_busy, cyc_done;
    logic [15:0] cyc_rdata;
    logic [22:0] pin_addr;
    logic cs_n_c, we_n_c, oe_n_c, dq_oe_c;
    logic [15:0] dq_o_c;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for flash pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_s1 <= 16'h0000;
            dq_sync <= 16'h0000;
            rb_s1 <= 1'b0;
            rb_sync <= 1'b0;
        end else begin
            dq_s1 <= flash_dq_i;
            dq_sync <= dq_s1;
            rb_s1 <= ready_busy_n;
            rb_sync <= rb_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write side: address and data in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = (aw_hold || aw_take) && (w_hold || w_take)
        && !s_axi_bvalid;
    wire [3:0] wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
    wire wr_ctrl = wr_fire && wr_addr == `FBC_OFS_CTRL;
    wire go_req = wr_ctrl && wr_data[`FBC_CTRL_GO] && state == ST_IDLE;
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (aw_take && !wr_fire) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take && !wr_fire) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register stores; go self-clears, byte masks ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `FBC_CTRL_RESET_VAL;
            reg_addr <= 23'h000000;
            reg_data <= 16'h0000;
        end else if (wr_fire) begin
            case (wr_addr)
                `FBC_OFS_CTRL: ctrl <= wr_data & ~32'h0000_0001;
                `FBC_OFS_ADDR: reg_addr <= wr_data[22:0];
                `FBC_OFS_DATA: reg_data <= wr_data[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side: one cycle answer
    wire [31:0] stat_word = {28'h0000000, bypass, done_flag, rb_sync,
        state != ST_IDLE};
    wire [31:0] rd_mux = (s_axi_araddr == `FBC_OFS_CTRL) ? ctrl :
        (s_axi_araddr == `FBC_OFS_ADDR) ? {9'h000, reg_addr} :
        (s_axi_araddr == `FBC_OFS_DATA) ? {16'h0000, rd_data} :
        (s_axi_araddr == `FBC_OFS_STAT) ? stat_word : 32'h0000_0000;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
        end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank and sector bits ride in reg_addr unchanged
    wire fbc_pkg::fbc_op_type op =
        fbc_pkg::fbc_op_type'(ctrl[`FBC_CTRL_OP_MSB:`FBC_CTRL_OP_LSB]);
    wire byte_mode = ctrl[`FBC_CTRL_BYTE];
    wire [22:0] unl_a = byte_mode ? 23'h000aaa : 23'h000555;
    wire [22:0] unl_b = byte_mode ? 23'h000555 : 23'h0002aa;
    wire accel = ctrl[`FBC_CTRL_ACCEL];
    wire bypass_like = bypass || accel;

    // Sequence length per operation, short program in bypass or boost
    always_comb begin
        case (op)
            fbc_pkg::FBC_OP_PROGRAM: seq_len = bypass_like ? 3'h2 : 3'h4;
            fbc_pkg::FBC_OP_BYPASS_ENTER: seq_len = 3'h3;
            fbc_pkg::FBC_OP_BYPASS_PROGRAM: seq_len = 3'h2;
            fbc_pkg::FBC_OP_BYPASS_EXIT: seq_len = 3'h2;
            fbc_pkg::FBC_OP_AUTOSELECT: seq_len = 3'h4;
            default: seq_len = 3'h1;
        endcase
    end

    // Bus cycle for the current sequence step
    wire short_prog = (op == fbc_pkg::FBC_OP_PROGRAM && bypass_like)
        || op == fbc_pkg::FBC_OP_BYPASS_PROGRAM;
    always_comb begin
        cyc.write = 1'b1;
        cyc.addr = reg_addr;
        cyc.data = reg_data;
        if (op == fbc_pkg::FBC_OP_READ) begin
            cyc.write = 1'b0;
        end else if (op == fbc_pkg::FBC_OP_WRITE) begin
            cyc.write = 1'b1;
        end else if (op == fbc_pkg::FBC_OP_RESET_CMD) begin
            cyc.data = 16'h00f0;
        end else if (short_prog) begin
            cyc.data = (seq_idx == 3'h0) ? 16'h00a0 : reg_data;
        end else if (op == fbc_pkg::FBC_OP_BYPASS_EXIT) begin
            cyc.data = (seq_idx == 3'h0) ? 16'h0090 : 16'h0000;
        end else if (seq_idx == 3'h0) begin
            cyc.addr = unl_a;
            cyc.data = 16'h00aa;
        end else if (seq_idx == 3'h1) begin
            cyc.addr = unl_b;
            cyc.data = 16'h0055;
        end else if (seq_idx == 3'h2) begin
            cyc.addr = (op == fbc_pkg::FBC_OP_PROGRAM) ? unl_a :
                {reg_addr[22:12], unl_a[11:0]};
            cyc.data = (op == fbc_pkg::FBC_OP_PROGRAM) ? 16'h00a0 :
                (op == fbc_pkg::FBC_OP_AUTOSELECT) ? 16'h0090 : 16'h0020;
        end else begin
            cyc.write = (op != fbc_pkg::FBC_OP_AUTOSELECT);
        end
    end

    assign start = (state == ST_ISSUE) && !cyc_busy;

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: if (tmr == 16'h0000) next_state = ST_RECOVER;
            ST_RECOVER: if (tmr == 16'h0000) next_state = ST_IDLE;
            ST_IDLE: if (go_req) next_state = ST_STANDBY_EXIT;
            ST_STANDBY_EXIT: if (tmr == 16'h0000) next_state = ST_ISSUE;
            ST_ISSUE: if (start) next_state = ST_WAIT;
            ST_WAIT: if (cyc_done)
                next_state = (seq_idx + 3'h1 == seq_len) ? ST_IDLE : ST_ISSUE;
            default: next_state = ST_IDLE;
        endcase
        if (wr_ctrl && wr_data[`FBC_CTRL_RESET])
            next_state = ST_RESET;
    end

    // State, timers and sequence index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_RESET;
            tmr <= RP_CYC[15:0];
            seq_idx <= 3'h0;
        end else begin
            state <= next_state;
            if (next_state != state)
                tmr <= (next_state == ST_RESET) ? RP_CYC[15:0] :
                    (next_state == ST_RECOVER) ? RH_CYC[15:0] :
                    (next_state == ST_STANDBY_EXIT) ? CE_CYC[15:0] :
                    16'h0000;
            else if (tmr != 16'h0000 && !(state == ST_RESET && !rb_sync))
                tmr <= tmr - 16'h0001;
            if (state == ST_IDLE)
                seq_idx <= 3'h0;
            else if (state == ST_WAIT && cyc_done)
                seq_idx <= seq_idx + 3'h1;
        end
    end

    // Done flag: set wins over clear by a status write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag <= 1'b0;
            rd_data <= 16'h0000;
            bypass <= 1'b0;
        end else begin
            if (state == ST_WAIT && next_state == ST_IDLE)
                done_flag <= 1'b1;
            else if (go_req || (wr_fire && wr_addr == `FBC_OFS_STAT))
                done_flag <= 1'b0;
            if (state == ST_WAIT && cyc_done && !cyc.write)
                rd_data <= byte_mode ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
            if (state == ST_RESET)
                bypass <= 1'b0;
            else if (state == ST_WAIT && next_state == ST_IDLE)
                bypass <= (op == fbc_pkg::FBC_OP_BYPASS_ENTER) ? 1'b1 :
                    (op == fbc_pkg::FBC_OP_BYPASS_EXIT ||
                    op == fbc_pkg::FBC_OP_RESET_CMD) ? 1'b0 : bypass;
        end
    end

    fbc_cycle u_cycle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start),
        .cyc(cyc),
        .dq_sync(dq_sync),
        .busy(cyc_busy),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .cs_n(cs_n_c),
        .we_n(we_n_c),
        .oe_n(oe_n_c),
        .addr(pin_addr),
        .dq_o(dq_o_c),
        .dq_oe_n(dq_oe_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin mapping; chip select high between cycles gives standby
    // Strobes forced high in reset: a cut cycle must not reach the pins
    assign chip_select_n = cs_n_c || !reset_n;
    assign write_strobe_n = we_n_c || !reset_n;
    assign output_gate_n = oe_n_c || !reset_n;
    assign reset_n = (state != ST_RESET);
    assign byte_mode_n = !byte_mode;
    assign protect_accelerate_pin = accel;
    assign flash_addr = byte_mode ? pin_addr[22:1] : pin_addr[21:0];
    // Top data line carries the low address bit in byte mode
    assign flash_dq_o = byte_mode ? {pin_addr[0], 7'h00, dq_o_c[7:0]}
        : dq_o_c;
    assign flash_dq_oe_n = byte_mode ? {1'b0, 7'h7f, {8{dq_oe_c}}}
        : {16{dq_oe_c}};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_cmd_pins;
        @(posedge aclk) disable iff (!aresetn)
        !write_strobe_n |-> !chip_select_n && output_gate_n;
    endproperty
    a_cmd_pins: assert property (p_cmd_pins)
        else $error("write strobe without command pin levels");
    property p_reset_held;
        @(posedge aclk) disable iff (!aresetn)
        $fell(reset_n) |-> !reset_n [*8];
    endproperty
    a_reset_held: assert property (p_reset_held)
        else $error("reset pulse too short");
    property p_no_cycle_in_reset;
        @(posedge aclk) disable iff (!aresetn)
        !reset_n |-> chip_select_n;
    endproperty
    a_no_cycle_in_reset: assert property (p_no_cycle_in_reset)
        else $error("flash selected during reset");
    property p_byte_pin;
        @(posedge aclk) disable iff (!aresetn)
        byte_mode_n == !ctrl[`FBC_CTRL_BYTE];
    endproperty
    a_byte_pin: assert property (p_byte_pin)
        else $error("byte select mismatch");
    property p_short_prog;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_ISSUE && short_prog |-> seq_len == 3'h2;
    endproperty
    a_short_prog: assert property (p_short_prog)
        else $error("bypass program not two cycles");
    c_program: cover property (@(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT && op == fbc_pkg::FBC_OP_PROGRAM ##1
        state == ST_IDLE);
    c_bypass: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(bypass));
    c_reset: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(reset_n));
endmodule
`default_nettype wire

/* test/fbc_flash_model.sv */
// Behavioural flash device at the controller's pins
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
    parameter int ACC_NS = 70,
    parameter int CE_NS = 16,
    parameter int RP_NS = 16,
    parameter int RH_NS = 16,
    parameter int BUSY_NS = 400,
    parameter int READY_NS = 100,
    parameter logic [15:0] AUTO_CODE = 16'h5a3c // Arbitrary value
) (
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] dq_o,
    input wire logic [15:0] dq_oe_n,
    input wire fbc_pkg::fbc_ctl_type ctl,
    input wire logic accel,
    output logic [15:0] dq_i,
    output logic ready_busy_n,
    output logic [15:0] wr_cnt,
    output logic [22:0] last_addr,
    output logic [15:0] last_data,
    output logic [7:0] err_cnt,
    output logic busy_reset
);
    realtime t_a = 0, t_cs = 0, t_rst = 0, t_rh = -1000, t_busy = 0;
    logic ok = 1'b0, tog = 1'b0, auto = 1'b0, prog = 1'b0, w_ok = 1'b0;
    logic [22:0] la, wa;
    logic [15:0] rd, mask, flt, wd;

    initial begin
        {wr_cnt, err_cnt, busy_reset, last_addr, last_data} = '0;
        ready_busy_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte mode takes the top data line as the lowest address bit
    assign la = ctl.byte_mode_n ? {1'b0, flash_addr} : {flash_addr, dq_o[15]};
    assign rd = auto ? AUTO_CODE : ~la[15:0];
    // Drive only when selected, gated, reading and out of reset
    assign mask = (!ctl.chip_select_n && !ctl.output_gate_n && ctl.reset_n &&
        ctl.write_strobe_n) ? (ctl.byte_mode_n ? 16'hffff : 16'h00ff) : '0;
    assign flt = {8{tog, ~tog}};
    // Released lines toggle so a stale value is never mistaken for data
    assign dq_i = (~dq_oe_n & dq_o) |
        (dq_oe_n & ((mask & (ok ? rd : ~rd)) | (~mask & flt)));

    always @(la) t_a = $realtime;

    // Half-step time base keeps sampling away from the clock edges
    initial begin
        #0.5;
        forever begin
            #1;
            tog = ~tog;
            ok = ($realtime - t_a >= ACC_NS)
                && ($realtime - t_cs >= CE_NS);
            ready_busy_n = $realtime >= t_busy;
            if (!ctl.write_strobe_n) begin
                if (ctl.chip_select_n || !ctl.output_gate_n) err_cnt++;
                w_ok = !ctl.chip_select_n && ctl.reset_n;
                wa = la;
                wd = ctl.byte_mode_n ? dq_o : {8'h00, dq_o[7:0]};
            end
        end
    end

    // Command latch on the rising write strobe
    always @(posedge ctl.write_strobe_n) begin
        if (w_ok) begin
            wr_cnt = wr_cnt + 16'h0001;
            last_addr = wa;
            last_data = wd;
            if (prog) t_busy = $realtime + (accel ? BUSY_NS / 4 : BUSY_NS);
            prog = wd[7:0] == 8'ha0;
            if (wd[7:0] == 8'h90) auto = 1'b1;
            if (wd[7:0] == 8'hf0) auto = 1'b0;
        end
        w_ok = 1'b0;
    end

    // Hardware reset aborts and returns to array read
    always @(negedge ctl.reset_n) begin
        t_rst = $realtime;
        auto = 1'b0;
        prog = 1'b0;
        if (!ready_busy_n) begin
            busy_reset = 1'b1;
            t_busy = $realtime + READY_NS;
        end
    end

    always @(posedge ctl.reset_n) begin
        if ($realtime - t_rst < RP_NS || !ready_busy_n) err_cnt++;
        t_rh = $realtime;
    end

    always @(negedge ctl.chip_select_n) begin
        t_cs = $realtime;
        if ($realtime - t_rh < RH_NS) err_cnt++;
    end
endmodule
`default_nettype wire

/* test/fbc_top_tb.sv */
// Self-checking bench for the flash bus controller
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defines.svh"
module fbc_top_tb;
    localparam int FAST_CYC = 4;
    localparam logic [15:0] AUTO = 16'h5a3c; // Arbitrary value
    // Kind: 1 last write, 2 read data, 3 bypass flag; nw f = not counted
    typedef struct packed {
        logic [2:0] op;
        logic [1:0] md;
        logic [22:0] ad;
        logic [15:0] dt;
        logic [3:0] nw;
        logic [1:0] k;
        logic [15:0] ex;
    } fbc_row_type;
    fbc_row_type rows [10] = '{
        '{3'h0, 2'b00, 23'h100321, 16'h0, 4'h0, 2'd2, 16'hfcde},
        '{3'h1, 2'b00, 23'h000aaa, 16'h0030, 4'h1, 2'd1, 16'h0},
        '{3'h2, 2'b00, 23'h012345, 16'hbeef, 4'h4, 2'd1, 16'h0},
        '{3'h2, 2'b01, 23'h2abcd5, 16'h00c3, 4'h4, 2'd1, 16'h0},
        '{3'h2, 2'b10, 23'h234567, 16'h1357, 4'h2, 2'd1, 16'h0},
        '{3'h3, 2'b00, 23'h0, 16'h0, 4'hf, 2'd3, 16'h1},
        '{3'h4, 2'b00, 23'h345678, 16'h2468, 4'h2, 2'd1, 16'h0},
        '{3'h5, 2'b00, 23'h0, 16'h0, 4'hf, 2'd3, 16'h0},
        '{3'h7, 2'b00, 23'h0, 16'h0, 4'h1, 2'd0, 16'h0},
        '{3'h6, 2'b00, 23'h200000, 16'h0, 4'h3, 2'd2, AUTO}
    };
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, accel, rb_n, busy_reset;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [21:0] flash_addr;
    logic [15:0] dq_i, dq_o, dq_oe_n, wr_cnt, last_data;
    logic chip_select_n, write_strobe_n, output_gate_n, reset_n, byte_mode_n;
    logic [22:0] last_addr;
    logic [7:0] err_cnt;
    fbc_pkg::fbc_ctl_type ctl;
    int bad_count = 0;
    int comparisons = 0;

    assign ctl = {chip_select_n, write_strobe_n, output_gate_n, reset_n,
        byte_mode_n};

    fbc_top #(.RP_CYC(FAST_CYC), .RH_CYC(FAST_CYC), .CE_CYC(FAST_CYC)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .flash_addr(flash_addr), .flash_dq_i(dq_i), .flash_dq_o(dq_o),
        .flash_dq_oe_n(dq_oe_n), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
        .reset_n(reset_n), .byte_mode_n(byte_mode_n),
        .protect_accelerate_pin(accel), .ready_busy_n(rb_n));

    fbc_flash_model #(.CE_NS(FAST_CYC * 4), .RP_NS(FAST_CYC * 4),
        .RH_NS(FAST_CYC * 4), .AUTO_CODE(AUTO)) u_flash (
        .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .ctl(ctl),
        .accel(accel), .dq_i(dq_i), .ready_busy_n(rb_n), .wr_cnt(wr_cnt),
        .last_addr(last_addr), .last_data(last_data), .err_cnt(err_cnt),
        .busy_reset(busy_reset));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run, shared with the watchdog
    task automatic finish_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (wvalid && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
    endtask

    // Poll status until masked bits match, flash out of reset
    task automatic wait_st(input logic [31:0] m, v);
        logic [31:0] s;
        do axi_rd(`FBC_OFS_STAT, s); while ((s & m) !== v || reset_n !== 1'b1);
    endtask

    task automatic run_op(input fbc_row_type r);
        logic [31:0] s;
        logic [15:0] c0;
        axi_wr(`FBC_OFS_ADDR, {9'h0, r.ad});
        axi_wr(`FBC_OFS_DATA, {16'h0, r.dt});
        c0 = wr_cnt;
        axi_wr(`FBC_OFS_CTRL, {26'h0, r.md, r.op, 1'b1});
        wait_st(32'h7, 32'h6);
        chk("accel pin", 32'(r.md[1]), 32'(accel));
        chk("byte select", 32'(!r.md[0]), 32'(byte_mode_n));
        if (r.nw != 4'hf) chk("cycles", 32'(r.nw), 32'(wr_cnt - c0));
        if (r.k == 2'd1) begin
            chk("write addr", 32'(r.ad), 32'(last_addr));
            chk("write data", 32'(r.dt), 32'(last_data));
        end
        if (r.k == 2'd2) begin
            axi_rd(`FBC_OFS_DATA, s);
            chk("read data", 32'(r.ex), 32'(s[15:0]));
        end
        if (r.k == 2'd3) begin
            axi_rd(`FBC_OFS_STAT, s);
            chk("bypass flag", 32'(r.ex[0]), 32'(s[3]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Watchdog well above the run time
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test;
    end

    initial begin
        logic [31:0] s;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`FBC_OFS_CTRL, s);
        chk("ctrl reset", `FBC_CTRL_RESET_VAL, s);
        wait_st(32'h3, 32'h2);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            run_op(rows[i]);
            $display("test row %0d done", i);
        end
        // Done flag clears on a status write
        axi_wr(`FBC_OFS_STAT, 32'h0);
        axi_rd(`FBC_OFS_STAT, s);
        chk("done clear", 32'h0, 32'(s[2]));
        $display("test done clear done");
        // Reset pulse while the device is still programming
        axi_wr(`FBC_OFS_ADDR, 32'h1000);
        axi_wr(`FBC_OFS_CTRL, 32'h5);
        do @(posedge aclk); while (rb_n !== 1'b0);
        axi_wr(`FBC_OFS_CTRL, 32'h40);
        repeat (4) @(posedge aclk);
        wait_st(32'h3, 32'h2);
        chk("reset in busy", 32'h1, 32'(busy_reset));
        run_op(rows[0]);
        run_op(rows[2]);
        chk("device faults", 32'h0, 32'(err_cnt));
        $display("test reset in busy done");
        finish_test;
    end
endmodule
`default_nettype wire
